// >>> src/bst_pkg.sv
// Contract
// - Test mode select is sampled at each rising test clock edge.
// - Test data input is captured at each rising test clock edge.
// - Test data output changes on the falling test clock edge only.
// - Test data output driver floats whenever no shift is in progress.
// - Mode select, data input and test reset read as one when undriven.
// - Instruction register is four bits, loaded serially from test data input.
// - Instruction bits shift in only in the shift-instruction state.
// - Current instruction picks active data register and serial path.
// - Serial input goes to instruction or data register per mode select history.
// - Single-bit pass register is one stage between data input and output.
// - Pin chain shifts out cell 0 first.
// - Three-state control cell enables its output driver when holding one.
// - Pin chain ends at cell 267; each transmit output cell precedes control.
// - Test clock independent; scanning never disturbs normal switch operation. The code samples tck on clk_i; each tck phase must span one clk_i cycle.
// - Identification instruction loads revision, device, vendor and presence bit.
// - Codes: 0000 extest, 1111 bypass, 0010 ident, 0011 float, 0001 sample.
// - Float instruction disables every output and selects the single-bit register.
// - Identification: revision 31:28, device 27:12, vendor 11:1, bit 0 one.
package bst_pkg;
  localparam int IR_W = 4;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SAMPLE = 4'h1;
  localparam logic [3:0] IR_IDCODE = 4'h2;
  localparam logic [3:0] IR_HIGHZ = 4'h3;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_RESET = IR_IDCODE;
  localparam int BSR_LEN = 268;
  localparam int N_STREAMS = 64;
  localparam int ID_W = 32;
  localparam int ID_REV_LSB = 28;
  localparam int ID_DEV_LSB = 12;
  localparam int ID_VEN_LSB = 1;
  localparam int CLK_NS = 20;
  localparam int TCK_MIN_NS = 100;
  localparam int TCK_MIN_CYC = (TCK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam int STS_IR_LSB = 0;
  localparam int STS_STATE_LSB = 4;
  localparam int STS_OE_BIT = 20;
  localparam int CTRL_HOLD_BIT = 0;

  typedef enum logic [15:0] {
    ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008, ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040, ST_EX2_DR = 16'h0080, ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000, ST_PAU_IR = 16'h2000, ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } bst_state_t;

  // Receive stream n input cell
  function automatic int bst_rx_cell(input int n);
    if (n >= 56) return 76 + (63 - n);
    else if (n >= 40) return 116 + (55 - n);
    else if (n >= 24) return 164 + (39 - n);
    else if (n >= 8) return 212 + (23 - n);
    else return 260 + (7 - n);
  endfunction

  // Transmit stream n output cell; its control cell is the next one
  function automatic int bst_tx_cell(input int n);
    if (n >= 48) return 84 + 2 * (63 - n);
    else if (n >= 32) return 132 + 2 * (47 - n);
    else if (n >= 16) return 180 + 2 * (31 - n);
    else return 228 + 2 * (15 - n);
  endfunction

  function automatic bst_state_t bst_next(input bst_state_t s, input logic tms);
    case (s)
      ST_RESET: return tms ? ST_RESET : ST_IDLE;
      ST_IDLE: return tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: return tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: return tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: return tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: return tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: return tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: return tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: return tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: return tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: return tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: return tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: return tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: return tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: return tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: return tms ? ST_SEL_DR : ST_IDLE;
      default: return ST_RESET;
    endcase
  endfunction
endpackage

// >>> src/bst_tap.sv
`timescale 1ns/10ps
module bst_tap import bst_pkg::*; #(
  parameter logic [3:0] ID_REVISION = 4'h1,   // Arbitrary value
  parameter logic [15:0] ID_DEVICE = 16'h5a5a, // Arbitrary value
  parameter logic [10:0] ID_VENDOR = 11'h155   // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic [N_STREAMS-1:0] rx_i,
  input wire logic [N_STREAMS-1:0] core_tx_i,
  input wire logic [N_STREAMS-1:0] core_tx_oe_i,
  output logic [N_STREAMS-1:0] tx_o,
  output logic [N_STREAMS-1:0] tx_oe_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  logic [2:0] tck_sync;
  logic [1:0] tms_sync;
  logic [1:0] tdi_sync;
  logic [1:0] trst_sync;
  logic [N_STREAMS-1:0] rx_meta;
  logic [N_STREAMS-1:0] rx_sync;
  logic tck_rise;
  logic tck_fall;
  logic tap_reset;
  logic ctrl_hold;
  bst_state_t state;
  logic [IR_W-1:0] ir_sr;
  logic [IR_W-1:0] ir;
  logic sel_bsr;
  logic sel_id;
  logic byp;
  logic [ID_W-1:0] id_sr;
  logic [ID_W-1:0] id_value;
  logic [BSR_LEN-1:0] pin_chain_register;
  logic [BSR_LEN-1:0] bsr_upd;
  logic [BSR_LEN-1:0] bsr_cap;
  logic next_tdo;
  logic wb_req;

  // Undriven pins settle high, so the mode select, data input and test reset synchronisers start at one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tck_sync <= 3'h0;
      tms_sync <= 2'h3;
      tdi_sync <= 2'h3;
      trst_sync <= 2'h3;
    end else begin
      tck_sync <= {tck_sync[1:0], tck_i};
      tms_sync <= {tms_sync[0], tms_i};
      tdi_sync <= {tdi_sync[0], tdi_i};
      trst_sync <= {trst_sync[0], trst_n_i};
    end
  end

  always_ff @(posedge clk_i) begin
    rx_meta <= rx_i;
    rx_sync <= rx_meta;
  end

  // Test clock needs each phase to span at least one system clock to be seen
  assign tck_rise = tck_sync[1] & ~tck_sync[2];
  assign tck_fall = ~tck_sync[1] & tck_sync[2];
  assign tap_reset = rst_i | ~trst_sync[1] | ctrl_hold;

  always_ff @(posedge clk_i) begin
    if (tap_reset) begin
      state <= ST_RESET;
    end else if (tck_rise) begin
      state <= bst_next(state, tms_sync[1]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (tap_reset) begin
      ir_sr <= IR_CAPTURE;
      ir <= IR_RESET;
    end else begin
      if (tck_rise && state == ST_CAP_IR) begin
        ir_sr <= IR_CAPTURE;
      end else if (tck_rise && state == ST_SH_IR) begin
        ir_sr <= {tdi_sync[1], ir_sr[IR_W-1:1]};
      end
      if (state == ST_RESET) begin
        ir <= IR_RESET;
      end else if (tck_fall && state == ST_UPD_IR) begin
        ir <= ir_sr;
      end
    end
  end

  // Reserved codes fall back to the single-bit path
  assign sel_bsr = (ir == IR_EXTEST) || (ir == IR_SAMPLE);
  assign sel_id = (ir == IR_IDCODE);

  assign id_value = {ID_REVISION, ID_DEVICE, ID_VENDOR, 1'b1};

  always_comb begin
    bsr_cap = bsr_upd;
    for (int n = 0; n < N_STREAMS; n++) begin
      bsr_cap[bst_rx_cell(n)] = rx_sync[n];
      bsr_cap[bst_tx_cell(n)] = tx_o[n];
      bsr_cap[bst_tx_cell(n) + 1] = tx_oe_o[n];
    end
  end

  always_ff @(posedge clk_i) begin
    if (tap_reset) begin
      byp <= 1'b0;
      id_sr <= '0;
      pin_chain_register <= '0;
    end else if (tck_rise && state == ST_CAP_DR) begin
      byp <= 1'b0;
      if (sel_id) begin
        id_sr <= id_value;
      end
      if (sel_bsr) begin
        pin_chain_register <= bsr_cap;
      end
    end else if (tck_rise && state == ST_SH_DR) begin
      if (sel_bsr) begin
        pin_chain_register <= {tdi_sync[1], pin_chain_register[BSR_LEN-1:1]};
      end else if (sel_id) begin
        id_sr <= {tdi_sync[1], id_sr[ID_W-1:1]};
      end else begin
        byp <= tdi_sync[1];
      end
    end
  end

  // Update stage keeps pin values steady while the chain shifts
  always_ff @(posedge clk_i) begin
    if (tap_reset) begin
      bsr_upd <= '0;
    end else if (tck_fall && state == ST_UPD_DR && sel_bsr) begin
      bsr_upd <= pin_chain_register;
    end
  end

  always_comb begin
    if (state == ST_SH_IR) begin
      next_tdo = ir_sr[0];
    end else if (sel_bsr) begin
      next_tdo = pin_chain_register[0];
    end else if (sel_id) begin
      next_tdo = id_sr[0];
    end else begin
      next_tdo = byp;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !trst_sync[1]) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_o <= next_tdo;
      tdo_oe_o <= (state == ST_SH_DR) || (state == ST_SH_IR);
    end
  end

  // Core path stays live except under extest or float
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_o <= '0;
      tx_oe_o <= '0;
    end else begin
      for (int n = 0; n < N_STREAMS; n++) begin
        if (ir == IR_HIGHZ) begin
          tx_o[n] <= core_tx_i[n];
          tx_oe_o[n] <= 1'b0;
        end else if (ir == IR_EXTEST) begin
          tx_o[n] <= bsr_upd[bst_tx_cell(n)];
          tx_oe_o[n] <= bsr_upd[bst_tx_cell(n) + 1];
        end else begin
          tx_o[n] <= core_tx_i[n];
          tx_oe_o[n] <= core_tx_oe_i[n];
        end
      end
    end
  end

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      ctrl_hold <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i && wb_adr_i == REG_STATUS) begin
        wb_dat_o[STS_IR_LSB +: IR_W] <= ir;
        wb_dat_o[STS_STATE_LSB +: 16] <= state;
        wb_dat_o[STS_OE_BIT] <= tdo_oe_o;
      end else if (wb_req && !wb_we_i && wb_adr_i == REG_CTRL) begin
        wb_dat_o[CTRL_HOLD_BIT] <= ctrl_hold;
      end
      // Write lands at the edge where the master sees ack, as classic cycles expect
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
          wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
        ctrl_hold <= wb_dat_i[CTRL_HOLD_BIT];
      end
    end
  end

  sequence s_rise_in(bst_state_t st);
    tck_rise && state == st;
  endsequence

  sequence s_fall_shift;
    tck_fall && (state == ST_SH_DR || state == ST_SH_IR);
  endsequence

  AST_TMS_SAMPLE: assert property (@(posedge clk_i) disable iff (tap_reset)
    s_rise_in(ST_IDLE) |=> state == ($past(tms_sync[1]) ? ST_SEL_DR : ST_IDLE))
    else $error("State did not follow sampled mode select");

  AST_BYP_SHIFT: assert property (@(posedge clk_i) disable iff (tap_reset)
    s_rise_in(ST_SH_DR) ##0 (ir == IR_BYPASS) |=> byp == $past(tdi_sync[1]))
    else $error("Single-bit register did not take data input");

  // Test reset clears the output at once, so it is excluded here
  AST_TDO_FALL: assert property (@(posedge clk_i) disable iff (tap_reset)
    $changed(tdo_o) |-> $past(tck_fall))
    else $error("Data output changed away from a falling edge");

  AST_TDO_FLOAT: assert property (@(posedge clk_i) disable iff (tap_reset)
    tck_fall && !(state == ST_SH_DR || state == ST_SH_IR) |=> !tdo_oe_o)
    else $error("Data output driven outside shift");

  AST_TDO_DRIVE: assert property (@(posedge clk_i) disable iff (tap_reset)
    s_fall_shift |=> tdo_oe_o && tdo_o == $past(next_tdo))
    else $error("Data output not driven during shift");

  AST_IR_ONLY_SHIFT: assert property (@(posedge clk_i) disable iff (tap_reset)
    $changed(ir_sr) |-> $past(state) == ST_SH_IR || $past(state) == ST_CAP_IR)
    else $error("Instruction shift register moved outside its states");

  AST_ID_LOAD: assert property (@(posedge clk_i) disable iff (tap_reset)
    s_rise_in(ST_CAP_DR) ##0 sel_id |=> id_sr == id_value && id_sr[0])
    else $error("Identification value not captured");

  AST_FLOAT_ALL: assert property (@(posedge clk_i) disable iff (rst_i)
    ir == IR_HIGHZ ##1 ir == IR_HIGHZ |-> tx_oe_o == '0)
    else $error("Output enabled under float instruction");

  AST_CTL_ENABLE: assert property (@(posedge clk_i) disable iff (rst_i)
    ir == IR_EXTEST |=> tx_oe_o[0] == $past(bsr_upd[259]) && tx_o[0] == $past(bsr_upd[258]))
    else $error("Control cell does not steer output enable");

  AST_TRST: assert property (@(posedge clk_i) disable iff (rst_i)
    !trst_sync[1] |=> (state == ST_RESET) [*2])
    else $error("Test reset did not force reset state");
endmodule

// >>> tb/bst_ctl_model.sv
`timescale 1ns/10ps
module bst_ctl_model (
  input wire logic clk_i,
  input wire logic tdo_i,
  input wire logic tdo_oe_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o
);
  // Undriven pins sit at the pulled-up level; tck stands low between frames
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_n_o = 1'b1;
  end
  // One test clock of 8 clk; tdo is read late in the high phase, long after the last fall
  task automatic step(input logic m, input logic d, output logic [1:0] seen);
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge clk_i);
    tck_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    // A floating output shows the inverse of its last value, so a missing drive shows up
    seen = {tdo_oe_i, tdo_oe_i ? tdo_i : ~tdo_i};
    tck_o <= 1'b0;
  endtask
  task automatic walk(input logic [7:0] seq, input int n);
    logic [1:0] s;
    for (int i = 0; i < n; i++) begin
      step(seq[i], 1'b1, s);
    end
  endtask
  task automatic pulse_reset();
    trst_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    trst_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb import bst_pkg::*; ();
  // Arbitrary identity values
  localparam logic [31:0] ID_EXP = {4'h3, 16'hc1d2, 11'h2a6, 1'b1};
  logic clk_i, rst_i, tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic [N_STREAMS-1:0] rx_i, core_tx_i, core_tx_oe_i, tx_o, tx_oe_o;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [267:0] dout;
  int failures, num_checks;
  bst_tap #(.ID_REVISION(4'h3), .ID_DEVICE(16'hc1d2), .ID_VENDOR(11'h2a6)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .rx_i(rx_i),
    .core_tx_i(core_tx_i), .core_tx_oe_i(core_tx_oe_i), .tx_o(tx_o), .tx_oe_o(tx_oe_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  bst_ctl_model ctl (.clk_i(clk_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 20) begin
      failures++;
      $display("ERROR %0t: bus answer missing", $time);
      print_verdict();
    end
  endtask
  // Shift n bits ending in exit1, then update and idle; oe must drop once idle
  task automatic shift(input int n, input logic [267:0] din);
    logic [1:0] s;
    for (int i = 0; i < n; i++) begin
      ctl.step(i == n - 1, din[i], s);
      dout[i] = s[0];
      chk(s[1], 1);
    end
    ctl.walk(8'h01, 2);
    repeat (6) @(posedge clk_i);
    chk(tdo_oe, 0);
  endtask
  task automatic load_ir(input logic [3:0] code);
    ctl.walk(8'h03, 4);
    shift(4, {264'h0, code});
    chk(dout[3:0], IR_CAPTURE);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd[3:0], code);
  endtask
  task automatic t_reset();
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd[20:0], {1'b0, ST_RESET, IR_IDCODE});
    wb(1'b0, 8'hf0, 32'h0);
    chk(rd, 0);
    chk({tx_oe_o, tx_o}, {core_tx_oe_i, core_tx_i});
    ctl.walk(8'h00, 1);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd[19:4], ST_IDLE);
  endtask
  task automatic t_ident();
    ctl.walk(8'h01, 3);
    shift(32, 268'h0);
    chk(dout[31:0], ID_EXP);
  endtask
  task automatic t_bypass();
    logic [3:0] c;
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? IR_BYPASS : (i == 1) ? IR_HIGHZ : 4'h7;
      load_ir(c);
      chk(tx_oe_o, (c == IR_HIGHZ) ? 64'h0 : core_tx_oe_i);
      ctl.walk(8'h01, 3);
      shift(8, 268'h5a);
      chk(dout[7:0], 8'hb4);
    end
  endtask
  // Preload drives tx0 and enables it; sample shows rx0 last and cell 0 first
  task automatic t_chain();
    load_ir(IR_SAMPLE);
    ctl.walk(8'h01, 3);
    shift(268, 268'h3 << 258);
    chk(dout[267:256], 12'h80e);
    load_ir(IR_EXTEST);
    chk({tx_oe_o, tx_o}, {64'h1, 64'h1});
  endtask
  task automatic t_trst();
    ctl.walk(8'h03, 4);
    ctl.pulse_reset();
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd[19:0], {ST_RESET, IR_IDCODE});
    wb(1'b1, REG_CTRL, 32'h1);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(rd[0], 1);
    ctl.walk(8'h00, 2);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd[19:4], ST_RESET);
  endtask
  initial begin
    failures = 0;
    num_checks = 0;
    rst_i = 1'b1;
    rx_i = 64'h1;
    core_tx_i = 64'ha5;
    core_tx_oe_i = {N_STREAMS{1'b1}};
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_ident();
    t_bypass();
    t_chain();
    t_trst();
    print_verdict();
  end
endmodule
